// >>> core/agrm_consts.vh
/*
  constants of the analog gain register bank: register offsets, field
  positions, reset values and gain scale factors.
  assumes it is included by bare name from the design files.
*/
`ifndef AGRM_CONSTS_VH
`define AGRM_CONSTS_VH

// register offsets on the sensor register port
`define AGRM_OFS_CAPABILITY 16'h0000
`define AGRM_OFS_GAIN_MODE 16'h0002
`define AGRM_OFS_LIN_GLOBAL 16'h0004
`define AGRM_OFS_LIN_GREENR 16'h0006
`define AGRM_OFS_LIN_RED 16'h0008
`define AGRM_OFS_LIN_BLUE 16'h000A
`define AGRM_OFS_LIN_GREENB 16'h000C
`define AGRM_OFS_STG_GLOBAL 16'h0010
`define AGRM_OFS_STG_GREENR 16'h0012
`define AGRM_OFS_STG_RED 16'h0014
`define AGRM_OFS_STG_BLUE 16'h0016
`define AGRM_OFS_STG_GREENB 16'h0018

// channel indices
`define AGRM_CH_GREENR 2'd0
`define AGRM_CH_RED 2'd1
`define AGRM_CH_BLUE 2'd2
`define AGRM_CH_GREENB 2'd3

// staged field positions
`define AGRM_STG_DBL_HI 8
`define AGRM_STG_DBL_LO 7
`define AGRM_STG_FINE_MSB 6
`define AGRM_STG_FINE_LSB 0

// fixed values
`define AGRM_CAPABILITY_VAL 16'h0001
`define AGRM_GAIN_MODE_RST 16'h0000
`define AGRM_LIN_RST 16'h0008
`define AGRM_STG_RST 16'h0220
`define AGRM_GAIN_RST 9'h020
`define AGRM_LIN_DIVISOR 8
`define AGRM_FINE_DIVISOR 32
`define AGRM_LIN_ONE_DBL_MAX 16'h003F
`define AGRM_LIN_TWO_DBL_MAX 16'h007F
`define AGRM_STG_SATURATE 16'h03FF

`endif

// >>> core/agrm_lin_to_stage.v
/*
  translates a linear gain code (gain = code / 8) into the staged setting.
  assumes a purely combinational use by the register bank.
*/
`timescale 1ns/1ps
`default_nettype none
`include "agrm_consts.vh"

module agrm_lin_to_stage (
  // linear code in
  input wire [15:0] linCode,
  // staged setting out
  output reg [15:0] stageVal
);

  always @* begin
    // fine/32 * 2 = code/8 -> fine = 2*code with the first doubling stage
    if (linCode <= `AGRM_LIN_ONE_DBL_MAX) begin
      stageVal = {7'h00, 1'b0, 1'b1, linCode[5:0], 1'b0};
    end else if (linCode <= `AGRM_LIN_TWO_DBL_MAX) begin
      // fine/32 * 4 = code/8 -> fine = code with both stages
      stageVal = {7'h00, 1'b1, 1'b1, linCode[6:0]};
    end else begin
      stageVal = `AGRM_STG_SATURATE;
    end
  end

endmodule // agrm_lin_to_stage
`default_nettype wire

// >>> core/agrm_stage_gain.v
/*
  turns a staged setting into the applied gain in units of 1/32.
  assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
`include "agrm_consts.vh"

module agrm_stage_gain (
  // staged setting
  input wire [15:0] stageVal,
  // gain times 32
  output wire [8:0] gainX32
);

  wire [6:0] fine;
  wire [8:0] fineWide;

  assign fine = stageVal[`AGRM_STG_FINE_MSB:`AGRM_STG_FINE_LSB];
  assign fineWide = {2'b00, fine};
  // each enabled doubling stage shifts the fine gain left once
  assign gainX32 = fineWide << ({1'b0, stageVal[`AGRM_STG_DBL_HI]}
                   + {1'b0, stageVal[`AGRM_STG_DBL_LO]});

endmodule // agrm_stage_gain
`default_nettype wire

// >>> core/agrm_regbank.v
/*
  analog gain register bank: capability, gain mode, linear-code set and
  staged set, with global aliasing and linear-to-staged translation.
  assumes a synchronous register port on core_clk; one access per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "agrm_consts.vh"

module agrm_regbank (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // register port
  input wire regWrEn,
  input wire regRdEn,
  input wire [15:0] regAddr,
  input wire [15:0] regWrData,
  output reg [15:0] regRdData,
  output reg regRdValid,
  output reg regAddrErr,
  // applied gain per channel, units of 1/32
  output reg [8:0] gainGreenR,
  output reg [8:0] gainRed,
  output reg [8:0] gainBlue,
  output reg [8:0] gainGreenB,
  // view last used per channel, bit set when written through linear codes
  output reg [3:0] linearViewLast
);

  ////////////////////////////////////////////////////////////////////////////
  // address decoding

  function [2:0] linChan;
    // bit 2 flags a hit, bits 1:0 give the channel
    input [15:0] addr;
    begin
      case (addr)
        `AGRM_OFS_LIN_GREENR: linChan = {1'b1, `AGRM_CH_GREENR};
        `AGRM_OFS_LIN_RED: linChan = {1'b1, `AGRM_CH_RED};
        `AGRM_OFS_LIN_BLUE: linChan = {1'b1, `AGRM_CH_BLUE};
        `AGRM_OFS_LIN_GREENB: linChan = {1'b1, `AGRM_CH_GREENB};
        default: linChan = 3'b000;
      endcase
    end
  endfunction

  function [2:0] stgChan;
    input [15:0] addr;
    begin
      case (addr)
        `AGRM_OFS_STG_GREENR: stgChan = {1'b1, `AGRM_CH_GREENR};
        `AGRM_OFS_STG_RED: stgChan = {1'b1, `AGRM_CH_RED};
        `AGRM_OFS_STG_BLUE: stgChan = {1'b1, `AGRM_CH_BLUE};
        `AGRM_OFS_STG_GREENB: stgChan = {1'b1, `AGRM_CH_GREENB};
        default: stgChan = 3'b000;
      endcase
    end
  endfunction

  wire [2:0] linHit;
  wire [2:0] stgHit;
  wire linGlobalHit;
  wire stgGlobalHit;
  wire modeHit;
  wire capHit;
  wire addrKnown;

  assign linHit = linChan(regAddr);
  assign stgHit = stgChan(regAddr);
  assign linGlobalHit = (regAddr == `AGRM_OFS_LIN_GLOBAL);
  assign stgGlobalHit = (regAddr == `AGRM_OFS_STG_GLOBAL);
  assign modeHit = (regAddr == `AGRM_OFS_GAIN_MODE);
  assign capHit = (regAddr == `AGRM_OFS_CAPABILITY);
  assign addrKnown = linHit[2] | stgHit[2] | linGlobalHit | stgGlobalHit
                     | modeHit | capHit;

  ////////////////////////////////////////////////////////////////////////////
  // storage

  reg [15:0] gainMode_r;
  reg [15:0] linCode_r [0:3];
  reg [15:0] stage_r [0:3];

  // translation of the incoming write data
  wire [15:0] translated;

  agrm_lin_to_stage u_lin_to_stage (
    .linCode(regWrData),
    .stageVal(translated)
  );

  // per-channel write strobes for each view
  reg [3:0] linWr;
  reg [3:0] stgWr;
  integer i;

  always @* begin
    linWr = 4'h0;
    stgWr = 4'h0;
    if (regWrEn) begin
      if (linGlobalHit) begin
        linWr = 4'hF;
      end else if (linHit[2]) begin
        linWr[linHit[1:0]] = 1'b1;
      end
      if (stgGlobalHit) begin
        stgWr = 4'hF;
      end else if (stgHit[2]) begin
        stgWr[stgHit[1:0]] = 1'b1;
      end
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gainMode_r <= `AGRM_GAIN_MODE_RST;
      for (i = 0; i < 4; i = i + 1) begin
        linCode_r[i] <= `AGRM_LIN_RST;
        stage_r[i] <= `AGRM_STG_RST;
      end
      linearViewLast <= 4'h0;
    end else begin
      // stored only; nothing in the gain path reads it
      if (regWrEn && modeHit) begin
        gainMode_r <= regWrData;
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (linWr[i]) begin
          linCode_r[i] <= regWrData;
          stage_r[i] <= translated;
          linearViewLast[i] <= 1'b1;
        end else if (stgWr[i]) begin
          // linear copy left stale, no reverse translation
          stage_r[i] <= regWrData;
          linearViewLast[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  reg [15:0] rdMux;

  always @* begin
    rdMux = 16'h0000;
    if (capHit) begin
      rdMux = `AGRM_CAPABILITY_VAL;
    end else if (modeHit) begin
      rdMux = gainMode_r;
    end else if (linGlobalHit) begin
      rdMux = linCode_r[`AGRM_CH_GREENR];
    end else if (stgGlobalHit) begin
      rdMux = stage_r[`AGRM_CH_GREENR];
    end else if (linHit[2]) begin
      rdMux = linCode_r[linHit[1:0]];
    end else if (stgHit[2]) begin
      rdMux = stage_r[stgHit[1:0]];
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 16'h0000;
      regRdValid <= 1'b0;
      regAddrErr <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      regAddrErr <= (regRdEn | regWrEn) & ~addrKnown;
      if (regRdEn) begin
        regRdData <= rdMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // applied gain

  wire [8:0] gainNxt [0:3];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_gain
      agrm_stage_gain u_stage_gain (
        .stageVal(stage_r[g]),
        .gainX32(gainNxt[g])
      );
    end
  endgenerate

  // a linear code c up to 0x7F yields 4*c (x32) i.e. c/8 through the staged value; larger codes saturate to 0x1FC
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gainGreenR <= `AGRM_GAIN_RST;
      gainRed <= `AGRM_GAIN_RST;
      gainBlue <= `AGRM_GAIN_RST;
      gainGreenB <= `AGRM_GAIN_RST;
    end else begin
      gainGreenR <= gainNxt[`AGRM_CH_GREENR];
      gainRed <= gainNxt[`AGRM_CH_RED];
      gainBlue <= gainNxt[`AGRM_CH_BLUE];
      gainGreenB <= gainNxt[`AGRM_CH_GREENB];
    end
  end

endmodule // agrm_regbank
`default_nettype wire

// >>> testbench/agrm_monitor.sv
/*
  port assertions for the analog gain register bank.
  assumes it is bound onto agrm_regbank, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module agrm_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid,
  input wire logic regAddrErr,
  // gains and view flags
  input wire logic [8:0] gainGreenR,
  input wire logic [8:0] gainRed,
  input wire logic [8:0] gainBlue,
  input wire logic [8:0] gainGreenB,
  input wire logic [3:0] linearViewLast
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_cap; regRdEn && regAddr == 16'h0000 |=> regRdValid && regRdData == 16'h0001;
  endproperty
  a_cap: assert property (p_cap) else $error("capability read wrong");
  property p_glb; regWrEn && regAddr == 16'h0010 |-> ##2 gainRed == gainGreenR &&
    gainBlue == gainGreenR && gainGreenB == gainGreenR; endproperty
  a_glb: assert property (p_glb) else $error("global write not copied");
  property p_mode; regWrEn && regAddr == 16'h0002 |-> ##2 $stable(gainRed); endproperty
  a_mode: assert property (p_mode) else $error("mode write moved gain");
  property p_rdOk; regRdEn && regAddr == 16'h000C |=> regRdValid && !regAddrErr; endproperty
  a_rdOk: assert property (p_rdOk) else $error("linear read refused");
  property p_lin; regWrEn && regAddr == 16'h0008 && regWrData <= 16'h007F
    |-> ##2 gainRed == {$past(regWrData[6:0], 2), 2'b00}; endproperty
  a_lin: assert property (p_lin) else $error("linear gain wrong");
  property p_stg; regWrEn && regAddr == 16'h0014 |-> ##2 gainRed == ({2'b00,
    $past(regWrData[6:0], 2)} << ({1'b0, $past(regWrData[8], 2)}
    + {1'b0, $past(regWrData[7], 2)})); endproperty
  a_stg: assert property (p_stg) else $error("staged gain wrong");
  property p_view; regWrEn && regAddr == 16'h0004 |-> ##[1:2] linearViewLast == 4'hF;
  endproperty
  a_view: assert property (p_view) else $error("view flags wrong");
  property p_hold; !regWrEn |-> ##2 $stable(gainBlue); endproperty
  a_hold: assert property (p_hold) else $error("gain moved without write");
  property p_err; (regWrEn || regRdEn) && regAddr > 16'h0018 |=> regAddrErr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  c_lin: cover property (regWrEn && regAddr == 16'h0008);
  c_glb: cover property (regWrEn && regAddr == 16'h0010);
  c_err: cover property (regAddrErr);
endmodule // agrm_monitor
`default_nettype wire

// >>> testbench/test_agrm_regbank.sv
/*
  self-checking bench for the gain register bank.
  assumes the core files and agrm_monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_agrm_regbank;
  logic core_clk = 0, rstn = 0, regWrEn = 0, regRdEn = 0;
  logic [15:0] regAddr = 16'h0000, regWrData = 16'h0000, c;
  logic [15:0] codes[4] = '{16'h0001, 16'h003F, 16'h0040, 16'h007F};
  wire [15:0] regRdData;
  wire regRdValid, regAddrErr;
  wire [8:0] gainGreenR, gainRed, gainBlue, gainGreenB;
  wire [3:0] linearViewLast;
  int n_fail = 0, n_tests = 0, cyc = 0;
  agrm_regbank DUT (.core_clk, .rstn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .regRdValid, .regAddrErr, .gainGreenR, .gainRed, .gainBlue, .gainGreenB, .linearViewLast);
  initial forever #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    regWrEn = 1;
    regAddr = a;
    regWrData = d;
    @(posedge core_clk) #1 regWrEn = 0;
    @(posedge core_clk) #1;
  endtask
  task automatic rd(input logic [15:0] a, exp, input logic err);
    regRdEn = 1;
    regAddr = a;
    @(posedge core_clk) #1 regRdEn = 0;
    chk(regRdData, exp);
    chk({regAddrErr, regRdValid}, {err, 1'b1});
    @(posedge core_clk) #1;
    chk({regRdValid, regAddrErr}, 2'b00);
  endtask
  task automatic gchk(input logic [8:0] a, b, d, e, input logic [3:0] v);
    @(posedge core_clk) #1;
    chk({gainGreenR, gainRed, gainBlue, gainGreenB, linearViewLast}, {a, b, d, e, v});
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk);
    #1 rstn = 1;
    gchk(9'h020, 9'h020, 9'h020, 9'h020, 4'h0);
    rd(16'h0000, 16'h0001, 0);
    wr(16'h0000, 16'h00FF);
    rd(16'h0000, 16'h0001, 0);
    wr(16'h0002, 16'h1234);
    rd(16'h0002, 16'h1234, 0);
    gchk(9'h020, 9'h020, 9'h020, 9'h020, 4'h0);
    wr(16'h0010, 16'h02A0);
    gchk(9'h040, 9'h040, 9'h040, 9'h040, 4'h0);
    for (int i = 0; i < 5; i++) rd(16'h0010 + 16'(2 * i), 16'h02A0, 0);
    wr(16'h0014, 16'h03C5);
    gchk(9'h040, 9'h114, 9'h040, 9'h040, 4'h0);
    rd(16'h0010, 16'h02A0, 0);
    foreach (codes[i]) begin
      c = codes[i];
      wr(16'h0008, c);
      gchk(9'h040, {c[6:0], 2'b00}, 9'h040, 9'h040, 4'h2);
      rd(16'h0014, c < 16'h0040 ? 16'h0080 | (c << 1) : 16'h0180 | c, 0);
      rd(16'h0008, c, 0);
    end
    wr(16'h0008, 16'h0080);
    gchk(9'h040, 9'h1FC, 9'h040, 9'h040, 4'h2);
    rd(16'h0014, 16'h03FF, 0);
    wr(16'h0004, 16'h0008);
    gchk(9'h020, 9'h020, 9'h020, 9'h020, 4'hF);
    rd(16'h0016, 16'h0090, 0);
    rd(16'h0004, 16'h0008, 0);
    wr(16'h0016, 16'h0240);
    gchk(9'h020, 9'h020, 9'h040, 9'h020, 4'hB);
    rd(16'h000A, 16'h0008, 0);
    rd(16'h0100, 16'h0000, 1);
    final_report;
  end
endmodule // test_agrm_regbank
bind agrm_regbank agrm_monitor MON (.core_clk, .rstn, .regWrEn, .regRdEn, .regAddr,
  .regWrData, .regRdData, .regRdValid, .regAddrErr, .gainGreenR, .gainRed, .gainBlue,
  .gainGreenB, .linearViewLast);
`default_nettype wire
